/* pdo_pkg.sv */
// pdo_pkg: constants and carrier types for the density output and alarm block
// assumes a 20 MHz system clock standing in for the internal oscillator
package pdo_pkg;
  localparam int PDO_DATA_W = 14;
  localparam int PDO_DIV_RATIO = 8;
  localparam logic [PDO_DATA_W-1:0] PDO_UP_SET_RST = 14'h3FFF;
  localparam logic [PDO_DATA_W-1:0] PDO_UP_CLR_RST = 14'h3FFF;
  localparam logic [PDO_DATA_W-1:0] PDO_LO_SET_RST = 14'h0000;
  localparam logic [PDO_DATA_W-1:0] PDO_LO_CLR_RST = 14'h0000;
  localparam int PDO_LO_POL_BIT = 7;
  localparam int PDO_LO_OD_BIT = 8;
  localparam int PDO_UP_POL_BIT = 9;
  localparam int PDO_UP_OD_BIT = 10;
  localparam logic [15:0] PDO_CFG_RST = 16'h0028;

  typedef enum logic [1:0] {
    PDO_SEL_UP_SET,
    PDO_SEL_UP_CLR,
    PDO_SEL_LO_SET,
    PDO_SEL_LO_CLR
  } pdo_sel_t;

  typedef struct packed {
    logic [PDO_DATA_W-1:0] upSet;
    logic [PDO_DATA_W-1:0] upClr;
    logic [PDO_DATA_W-1:0] loSet;
    logic [PDO_DATA_W-1:0] loClr;
  } pdo_thr_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pdo_pin_t;
endpackage : pdo_pkg

/* pdo_output_stage.sv */
// pdo_output_stage: two density-modulated outputs and two hysteresis alarm pins
// assumes conversion results and the threshold/config writes come from same-clock logic
`timescale 1ns/1ps
module pdo_output_stage
  import pdo_pkg::*;
#(
  parameter int DATA_W = PDO_DATA_W,
  parameter int DIV_RATIO = PDO_DIV_RATIO
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,

  // conversion results
  input wire logic convDone,
  input wire logic [DATA_W-1:0] humidityCode,
  input wire logic [DATA_W-1:0] temperatureCode,

  // mode: density output mode shares the lower alarm pad with temperature
  input wire logic densityMode,

  // threshold and configuration writes
  input wire logic thrWrite,
  input wire pdo_sel_t thrSel,
  input wire logic [DATA_W-1:0] thrData,
  input wire logic cfgWrite,
  input wire logic [15:0] cfgData,

  // readback
  output logic [DATA_W-1:0] thrReadData,
  output logic [15:0] cfgReadData,

  // pins
  output logic humidity_density_out,
  output logic temperature_density_out,
  output logic upperAlarmO,
  output logic upperAlarmOe,
  output logic lowerAlarmO,
  output logic lowerAlarmOe,

  // raw alarm states
  output logic upperAlarmActive,
  output logic lowerAlarmActive
);

  typedef struct packed {
    logic [2:0] divCnt;
    logic [DATA_W-1:0] humVal;
    logic [DATA_W-1:0] tmpVal;
    logic [DATA_W-1:0] humAcc;
    logic [DATA_W-1:0] tmpAcc;
    logic humBit;
    logic tmpBit;
    pdo_thr_t thr;
    logic [15:0] cfg;
    logic upAct;
    logic loAct;
    pdo_pin_t upPin;
    pdo_pin_t loPin;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // first-order sigma-delta step: carry out of the accumulator is the output bit
  function automatic logic [DATA_W:0] pdmStep(input logic [DATA_W-1:0] acc,
                                              input logic [DATA_W-1:0] val);
    pdmStep = {1'b0, acc} + {1'b0, val};
  endfunction : pdmStep

  // hysteresis: "rising" alarms trip at or above onLvl, release at or below offLvl
  function automatic logic hyst(input logic act, input logic rising,
                                input logic [DATA_W-1:0] h,
                                input logic [DATA_W-1:0] onLvl,
                                input logic [DATA_W-1:0] offLvl);
    if (rising) begin
      if (act) begin
        hyst = (h > offLvl);
      end else begin
        hyst = (h >= onLvl);
      end
    end else begin
      if (act) begin
        hyst = (h < offLvl);
      end else begin
        hyst = (h <= onLvl);
      end
    end
  endfunction : hyst

  // pin drive: open drain only ever pulls low
  function automatic pdo_pin_t drivePin(input logic act, input logic pol, input logic od);
    logic lvl;
    lvl = act ^ pol;
    if (od) begin
      // a released pad rests at the external pull level, so never drive it high
      drivePin.o = 1'b0;
      drivePin.oe = ~lvl;
    end else begin
      drivePin.o = lvl;
      drivePin.oe = 1'b1;
    end
  endfunction : drivePin

  // last clock of one density bit period
  function automatic logic divWrap(input logic [2:0] cnt);
    divWrap = (cnt == 3'(DIV_RATIO - 1));
  endfunction : divWrap

  // upper pin: inverted polarity turns it into a low alarm with the pair swapped
  function automatic logic upperNext(input logic act, input logic pol,
                                     input logic [DATA_W-1:0] h,
                                     input pdo_thr_t t);
    if (pol) begin
      upperNext = hyst(act, 1'b0, h, t.upClr, t.upSet);
    end else begin
      upperNext = hyst(act, 1'b1, h, t.upSet, t.upClr);
    end
  endfunction : upperNext

  // lower pin: inverted polarity turns it into a high alarm, clear level trips
  function automatic logic lowerNext(input logic act, input logic pol,
                                     input logic [DATA_W-1:0] h,
                                     input pdo_thr_t t);
    if (pol) begin
      lowerNext = hyst(act, 1'b1, h, t.loClr, t.loSet);
    end else begin
      lowerNext = hyst(act, 1'b0, h, t.loSet, t.loClr);
    end
  endfunction : lowerNext

  // streams low, alarms idle, push-pull pins driven low, table defaults loaded
  function automatic st_t rstState();
    rstState = '0;
    rstState.thr.upSet = PDO_UP_SET_RST;
    rstState.thr.upClr = PDO_UP_CLR_RST;
    rstState.thr.loSet = PDO_LO_SET_RST;
    rstState.thr.loClr = PDO_LO_CLR_RST;
    rstState.cfg = PDO_CFG_RST;
    rstState.upPin.oe = 1'b1;
    rstState.loPin.oe = 1'b1;
  endfunction : rstState

  logic [DATA_W:0] humSum;
  logic [DATA_W:0] tmpSum;
  logic upPol;
  logic loPol;
  logic wrap;
  logic upNext;
  logic loNext;
  logic upOd;
  logic loOd;

  always_comb begin
    st_nxt = st_r;
    humSum = pdmStep(st_r.humAcc, st_r.humVal);
    tmpSum = pdmStep(st_r.tmpAcc, st_r.tmpVal);
    upPol = st_r.cfg[PDO_UP_POL_BIT];
    loPol = st_r.cfg[PDO_LO_POL_BIT];
    wrap = divWrap(st_r.divCnt);
    // candidates come from the humidity code only
    upNext = upperNext(st_r.upAct, upPol, humidityCode, st_r.thr);
    loNext = lowerNext(st_r.loAct, loPol, humidityCode, st_r.thr);

    if (wrap) begin
      st_nxt.divCnt = 3'h0;
    end else begin
      st_nxt.divCnt = st_r.divCnt + 3'h1;
    end

    // fraction of ones is code over full scale
    if (wrap) begin
      st_nxt.humAcc = humSum[DATA_W-1:0];
      st_nxt.humBit = humSum[DATA_W];
      // temperature keeps running outside density mode; the pad mux hides it
      st_nxt.tmpAcc = tmpSum[DATA_W-1:0];
      st_nxt.tmpBit = tmpSum[DATA_W];
    end

    if (thrWrite) begin
      case (thrSel)
        PDO_SEL_UP_SET: begin
          st_nxt.thr.upSet = thrData;
        end
        PDO_SEL_UP_CLR: begin
          st_nxt.thr.upClr = thrData;
        end
        PDO_SEL_LO_SET: begin
          st_nxt.thr.loSet = thrData;
        end
        PDO_SEL_LO_CLR: begin
          st_nxt.thr.loClr = thrData;
        end
        default: begin
          st_nxt.thr = st_r.thr;
        end
      endcase
    end

    if (cfgWrite) begin
      st_nxt.cfg = cfgData;
    end

    if (convDone) begin
      // new values take effect at conversion end
      st_nxt.humVal = humidityCode;
      st_nxt.tmpVal = temperatureCode;
      // outside reset, alarms move only here and hold otherwise
      st_nxt.upAct = upNext;
      st_nxt.loAct = loNext;
    end

    // polarity and driver from the word being loaded
    // so a config write and the pin change land on the same edge
    upOd = st_nxt.cfg[PDO_UP_OD_BIT];
    loOd = st_nxt.cfg[PDO_LO_OD_BIT];
    st_nxt.upPin = drivePin(st_nxt.upAct, st_nxt.cfg[PDO_UP_POL_BIT], upOd);
    st_nxt.loPin = drivePin(st_nxt.loAct, st_nxt.cfg[PDO_LO_POL_BIT], loOd);

    // reset last so it overrides every update above
    if (srst) begin
      st_nxt = rstState();
    end
  end

  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  always_comb begin
    case (thrSel)
      PDO_SEL_UP_SET: begin
        thrReadData = st_r.thr.upSet;
      end
      PDO_SEL_UP_CLR: begin
        thrReadData = st_r.thr.upClr;
      end
      PDO_SEL_LO_SET: begin
        thrReadData = st_r.thr.loSet;
      end
      PDO_SEL_LO_CLR: begin
        thrReadData = st_r.thr.loClr;
      end
      default: begin
        thrReadData = '0;
      end
    endcase
  end

  assign cfgReadData = st_r.cfg;
  assign humidity_density_out = st_r.humBit;
  assign upperAlarmO = st_r.upPin.o;
  assign upperAlarmOe = st_r.upPin.oe;

  // lower pad carries temperature density in density mode
  // the stream is driven hard there, whatever the lower driver type says
  always_comb begin
    if (densityMode) begin
      temperature_density_out = st_r.tmpBit;
      lowerAlarmO = st_r.tmpBit;
      lowerAlarmOe = 1'b1;
    end else begin
      temperature_density_out = 1'b0;
      lowerAlarmO = st_r.loPin.o;
      lowerAlarmOe = st_r.loPin.oe;
    end
  end

  assign upperAlarmActive = st_r.upAct;
  assign lowerAlarmActive = st_r.loAct;

endmodule : pdo_output_stage

/* pdo_props.sv */
// pdo_props: density bit timing and alarm hysteresis checks
// sees only the stage ports; the bench keeps each threshold pair ordered
`timescale 1ns/1ps
module pdo_props
  import pdo_pkg::*;
(
  // clock, reset, inputs and readback
  input wire logic sys_clk, srst, convDone, densityMode,
  input wire pdo_sel_t thrSel,
  input wire logic [PDO_DATA_W-1:0] humidityCode, thrReadData,
  input wire logic [15:0] cfgReadData,
  // outputs
  input wire logic humidity_density_out, temperature_density_out,
  input wire logic upperAlarmO, upperAlarmOe, lowerAlarmO, lowerAlarmOe,
  input wire logic upperAlarmActive, lowerAlarmActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_sel(pdo_sel_t k);
    convDone && thrSel == k;
  endsequence
  AST_HUM_BIT:
  assert property ($changed(humidity_density_out) && !$past(srst)
    |=> $stable(humidity_density_out)[*7]) else $error("humidity bit too short");
  AST_TMP_BIT:
  assert property ($changed(temperature_density_out) && densityMode && $past(densityMode)
    && !$past(srst)
    |=> ($stable(temperature_density_out) || !densityMode)[*7])
    else $error("temperature bit too short");
  AST_TMP_IDLE:
  assert property (!densityMode && !$past(densityMode) && !$past(srst)
    |-> !temperature_density_out) else $error("temperature stream outside mode");
  AST_LO_PAD:
  assert property (densityMode && $past(densityMode)
    |-> lowerAlarmOe && lowerAlarmO == temperature_density_out)
    else $error("lower pad not temperature");
  AST_UP_SET:
  assert property (s_sel(PDO_SEL_UP_SET) ##0 (!cfgReadData[9] && humidityCode >= thrReadData)
    |=> upperAlarmActive) else $error("upper alarm did not set");
  AST_UP_CLR:
  assert property (s_sel(PDO_SEL_UP_CLR) ##0 (!cfgReadData[9] && humidityCode <= thrReadData)
    |=> !upperAlarmActive) else $error("upper alarm did not clear");
  AST_LO_SET:
  assert property (s_sel(PDO_SEL_LO_SET) ##0 (!cfgReadData[7] && humidityCode <= thrReadData)
    |=> lowerAlarmActive) else $error("lower alarm did not set");
  AST_HOLD:
  assert property (!$past(convDone) && !$past(srst)
    |-> $stable({upperAlarmActive, lowerAlarmActive})) else $error("alarm moved idle");
  AST_UP_PIN:
  assert property ($stable(cfgReadData) && !$past(srst) |-> upperAlarmOe ==
    (!cfgReadData[10] || !(upperAlarmActive ^ cfgReadData[9])) && upperAlarmO ==
    (!cfgReadData[10] && (upperAlarmActive ^ cfgReadData[9]))) else $error("upper pin drive");
endmodule : pdo_props
bind pdo_output_stage pdo_props u_props (.*);

/* pdo_load.sv */
// pdo_load: pull-up load on both alarm pads, as a host input sees them
// assumes Oe high means the stage drives the pad
`timescale 1ns/1ps
module pdo_load (
  // pads
  input wire logic upO, upOe, loO, loOe,
  // levels seen
  output logic upLvl, loLvl
);
  assign upLvl = upOe ? upO : 1'b1;
  assign loLvl = loOe ? loO : 1'b1;
endmodule : pdo_load

/* pdo_output_stage_tb.sv */
// pdo_output_stage_tb: random conversions against an integer reference model
// assumes the pull-up load of pdo_load on both alarm pads
`timescale 1ns/1ps
module pdo_output_stage_tb
  import pdo_pkg::*;
;
  logic sys_clk = 0, srst = 1, convDone = 0, densityMode = 0, thrWrite = 0, cfgWrite = 0;
  logic [13:0] humidityCode = 0, temperatureCode = 0, thrData = 0, thrReadData;
  logic [15:0] cfgData = 16'h0028, cfgReadData;
  pdo_sel_t thrSel = PDO_SEL_UP_SET;
  logic hOut, tOut, uO, uOe, lO, lOe, uAct, lAct, uLvl, lLvl;
  int mismatches = 0, n_tests = 0, seed = 3, thr[4], ua = 0, la = 0, n1, n2;
  pdo_output_stage i_dut (.sys_clk, .srst, .convDone, .humidityCode, .temperatureCode,
    .densityMode, .thrWrite, .thrSel, .thrData, .cfgWrite, .cfgData, .thrReadData,
    .cfgReadData, .humidity_density_out(hOut), .temperature_density_out(tOut),
    .upperAlarmO(uO), .upperAlarmOe(uOe), .lowerAlarmO(lO), .lowerAlarmOe(lOe),
    .upperAlarmActive(uAct), .lowerAlarmActive(lAct));
  pdo_load i_load (.upO(uO), .upOe(uOe), .loO(lO), .loOe(lOe), .upLvl(uLvl), .loLvl(lLvl));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic wr(input int k, input int d);
    @(negedge sys_clk);
    thrWrite = 1;
    thrSel = pdo_sel_t'(k);
    thrData = d[13:0];
    thr[k] = d;
    @(negedge sys_clk);
    thrWrite = 0;
    chk("thr", thrReadData, d);
  endtask : wr
  task automatic conv(input int h);
    @(negedge sys_clk);
    convDone = 1;
    humidityCode = h[13:0];
    thrSel = pdo_sel_t'($random(seed) & 3);
    @(negedge sys_clk);
    convDone = 0;
    if (!cfgData[9]) begin if (h >= thr[0]) ua = 1; else if (h <= thr[1]) ua = 0; end
    else begin if (h <= thr[1]) ua = 1; else if (h >= thr[0]) ua = 0; end
    if (!cfgData[7]) begin if (h <= thr[2]) la = 1; else if (h >= thr[3]) la = 0; end
    else begin if (h >= thr[3]) la = 1; else if (h <= thr[2]) la = 0; end
    chk("upAct", uAct, ua);
    chk("loAct", lAct, la);
    chk("upLvl", uLvl, ua ^ cfgData[9]);
    chk("upOe", uOe, !cfgData[10] || !(ua ^ cfgData[9]));
    if (!densityMode) chk("loLvl", lLvl, la ^ cfgData[7]);
  endtask : conv
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 0;
    for (int k = 0; k < 4; k++) begin
      thrSel = pdo_sel_t'(k);
      @(negedge sys_clk);
      chk("thrRst", thrReadData, k < 2 ? 14'h3FFF : 14'h0000);
    end
    chk("cfgRst", cfgReadData, 16'h0028);
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      cfgWrite = 1;
      cfgData = 16'h0028 | 16'(i << 7);
      @(negedge sys_clk);
      cfgWrite = 0;
      chk("cfg", cfgReadData, cfgData);
      wr(0, 14'h3000);
      wr(1, 14'h2000);
      wr(2, 14'h1000);
      wr(3, 14'h1800);
      foreach (thr[k]) conv(thr[k]);
      repeat (16) conv($random(seed) & 14'h3FFF);
    end
    densityMode = 1;
    temperatureCode = 14'h1000;
    conv(14'h2000);
    repeat (16) @(negedge sys_clk);
    n1 = 0;
    n2 = 0;
    repeat (16384) begin
      @(negedge sys_clk);
      n1 += hOut;
      n2 += tOut;
    end
    chk("hFrac", n1 >= 8176 && n1 <= 8208, 1);
    chk("tFrac", n2 >= 4080 && n2 <= 4112, 1);
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end
endmodule : pdo_output_stage_tb
